// ==== core/dbrake_pkg.sv ====
// shared constants and types for the dynamic brake sequencer
package dbrake_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    // timing figures in their own units
    localparam int unsigned ACT_TIME_US    = 800;
    localparam int unsigned FB_TIMEOUT_MS  = 100;
    localparam int unsigned READY_TIME_MS  = 30;
    // longest times round down to whole cycles
    localparam int unsigned ACT_CYCLES     = (CLK_HZ / 1000000) * ACT_TIME_US;
    localparam int unsigned FB_TIMEOUT_CYC = (CLK_HZ / 1000) * FB_TIMEOUT_MS;
    localparam int unsigned READY_CYC      = (CLK_HZ / 1000) * READY_TIME_MS;
    localparam int unsigned CNT_W          = 24;
    // bus voltage thresholds in volts, 10 bit code of volts
    localparam int unsigned VBUS_W         = 10;
    localparam logic [9:0]  REGEN_ON_V     = 10'h190; // 400 V
    localparam logic [9:0]  OVERVOLT_V     = 10'h1A4; // 420 V
    localparam int unsigned PWM_W          = 8;
    // register map, byte addresses of word registers
    localparam int unsigned ADDR_W         = 4;
    localparam logic [3:0]  ADDR_STATUS    = 4'h0;
    localparam logic [3:0]  ADDR_MASK      = 4'h4;
    localparam logic [3:0]  ADDR_REGEN     = 4'h8;
    localparam logic [3:0]  ADDR_STATE     = 4'hC;
    localparam int unsigned EVT_W          = 4;
    localparam int unsigned EVT_FB_TMO     = 0;
    localparam int unsigned EVT_OVERVOLT   = 1;
    localparam int unsigned EVT_ACTIVE     = 2;
    localparam int unsigned EVT_READY      = 3;
    localparam logic [3:0]  MASK_RESET     = 4'h0;
    localparam logic [15:0] REGEN_RESET    = 16'h0000;
    localparam logic [1:0]  SEQ_SEL_RESET  = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_READY   = 3'b001,
        ST_RELAY   = 3'b010,
        ST_WAIT_FB = 3'b011,
        ST_ACTIVE  = 3'b100,
        ST_ALARM   = 3'b101,
        ST_RECHECK = 3'b110
    } seq_state_t;

    // regen resistor settings, written by software
    typedef struct packed {
        logic [7:0] resistance;
        logic [7:0] power;
    } regen_cfg_t;
endpackage : dbrake_pkg

// ==== core/regen_pwm.sv ====
// pwm switch for the regeneration resistor
`timescale 1ns/10ps
module regen_pwm
    import dbrake_pkg::*;
(
    input  wire logic               clk,      // control clock
    input  wire logic               rst_n,    // async reset
    input  wire logic [VBUS_W-1:0]  vbus,     // bus voltage code
    input  wire logic [PWM_W-1:0]   duty,     // duty from settings
    output logic                    sw_on     // resistor switch
);
    logic [PWM_W-1:0] phase_reg;
    logic             sw_reg;
    wire              regen_zone = (vbus >= REGEN_ON_V);

    // free running phase, switch compares against duty
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= '0;
            sw_reg    <= 1'b0;
        end else begin
            phase_reg <= phase_reg + 1'b1;
            sw_reg    <= regen_zone && (phase_reg < duty);
        end
    end
    assign sw_on = sw_reg;
endmodule : regen_pwm

// ==== core/dbrake_seq.sv ====
// dynamic brake sequencer with alarms, regen pwm and avalon registers
//
// Behaviour
// - relay output on within 800 us of run
// - feedback within 100 ms else timeout alarm
// - servo active within 800 us of feedback
// - any alarm drops ready and relay output
// - alarm clear only while run is off
// - fault clear rechecks, ready within 30 ms
// - run off drops servo and relay quickly
// - relay open before power stage on
// - regen resistor switched by pwm
// - regen near 400 V, alarm at 420 V
`timescale 1ns/10ps
module dbrake_seq
    import dbrake_pkg::*;
(
    input  wire logic               REF_CLK,        // 20 MHz control clock
    input  wire logic               RSTN,           // async reset, active low
    input  wire logic               RUN_REQ,        // host run request pin
    input  wire logic               FAULT_CLEAR,    // host fault clear pin
    input  wire logic               BRAKE_FB,       // brake feedback input pin
    input  wire logic [VBUS_W-1:0]  VBUS,           // bus voltage code, same clock
    output logic                    SERVO_READY,    // servo ready output
    output logic                    BRAKE_RELAY,    // brake relay output
    output logic                    SERVO_ACTIVE,   // power stage enable
    output logic                    REGEN_SW,       // regen resistor switch
    output logic                    IRQ,            // level interrupt
    input  wire logic [ADDR_W-1:0]  avs_address,    // byte address
    input  wire logic               avs_read,       // read strobe
    input  wire logic               avs_write,      // write strobe
    input  wire logic [31:0]        avs_writedata,  // write data
    input  wire logic [3:0]         avs_byteenable, // byte lanes
    output logic [31:0]             avs_readdata,   // read data
    output logic                    avs_waitrequest // stall
);
    // three stage synchronisers for pins
    logic [2:0] run_sync_reg, clr_sync_reg, fb_sync_reg;
    logic       run_reg, clr_reg, fb_reg;
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            run_sync_reg <= '0;
            clr_sync_reg <= '0;
            fb_sync_reg  <= '0;
        end else begin
            run_sync_reg <= {run_sync_reg[1:0], RUN_REQ};
            clr_sync_reg <= {clr_sync_reg[1:0], FAULT_CLEAR};
            fb_sync_reg  <= {fb_sync_reg[1:0], BRAKE_FB};
        end
    end
    // a change counts once stages two and three agree
    wire run_agree = (run_sync_reg[1] == run_sync_reg[2]);
    wire clr_agree = (clr_sync_reg[1] == clr_sync_reg[2]);
    wire fb_agree  = (fb_sync_reg[1] == fb_sync_reg[2]);
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            run_reg <= 1'b0;
            clr_reg <= 1'b0;
            fb_reg  <= 1'b0;
        end else begin
            run_reg <= run_agree ? run_sync_reg[2] : run_reg;
            clr_reg <= clr_agree ? clr_sync_reg[2] : clr_reg;
            fb_reg  <= fb_agree ? fb_sync_reg[2] : fb_reg;
        end
    end

    // sequencer state and counters
    seq_state_t       state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic             ready_reg, relay_reg, active_reg;
    logic             fb_tmo_alarm_reg;
    logic             ov_alarm_reg;
    logic             clr_prev_reg;

    wire ov_now        = (VBUS >= OVERVOLT_V);
    wire any_alarm     = fb_tmo_alarm_reg | ov_alarm_reg;
    wire clr_rise      = clr_reg & ~clr_prev_reg;
    wire clear_allowed = clr_rise & ~run_reg;
    wire fb_expired    = (cnt_reg >= CNT_W'(FB_TIMEOUT_CYC - 1));
    wire ready_done    = (cnt_reg >= CNT_W'(READY_CYC - 1));
    wire fb_tmo_set    = (state_reg == ST_WAIT_FB) && run_reg && !fb_reg && fb_expired;

    // next state logic
    always_comb begin
        state_next = state_reg;
        cnt_next   = '0;
        unique case (state_reg)
            ST_IDLE: begin
                // ready only after a clean power up with no alarm
                if (!any_alarm) begin
                    state_next = ST_RECHECK;
                end
            end
            ST_READY: begin
                if (run_reg) begin
                    state_next = ST_RELAY;
                end
            end
            ST_RELAY: begin
                state_next = ST_WAIT_FB;
            end
            ST_WAIT_FB: begin
                cnt_next = cnt_reg + 1'b1;
                if (!run_reg) begin
                    state_next = ST_READY;
                end else if (fb_reg) begin
                    state_next = ST_ACTIVE;
                end else if (fb_expired) begin
                    state_next = ST_ALARM;
                end
            end
            ST_ACTIVE: begin
                if (!run_reg) begin
                    state_next = ST_READY;
                end
            end
            ST_ALARM: begin
                if (clear_allowed) begin
                    state_next = ST_RECHECK;
                end
            end
            ST_RECHECK: begin
                cnt_next = cnt_reg + 1'b1;
                if (ready_done) begin
                    state_next = ST_READY;
                end
            end
            default: begin
                state_next = ST_ALARM;
            end
        endcase
        // any alarm overrides the sequence
        if (any_alarm && state_reg != ST_ALARM && !(state_reg == ST_IDLE)) begin
            state_next = ST_ALARM;
            cnt_next   = '0;
        end
        if (fb_tmo_set || ov_now) begin
            state_next = ST_ALARM;
            cnt_next   = '0;
        end
    end

    // output decode, power stage only in ACTIVE, entered on feedback with relay held on
    wire ready_next  = (state_next == ST_READY) || (state_next == ST_RELAY) ||
                       (state_next == ST_WAIT_FB) || (state_next == ST_ACTIVE);
    wire relay_next  = (state_next == ST_RELAY) || (state_next == ST_WAIT_FB) ||
                       (state_next == ST_ACTIVE);
    wire active_next = (state_next == ST_ACTIVE);

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_reg    <= ST_IDLE;
            cnt_reg      <= '0;
            ready_reg    <= 1'b0;
            relay_reg    <= 1'b0;
            active_reg   <= 1'b0;
            clr_prev_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            ready_reg    <= ready_next;
            relay_reg    <= relay_next;
            active_reg   <= active_next;
            clr_prev_reg <= clr_reg;
        end
    end

    // alarm latches, released only by an allowed clear with the cause gone
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            fb_tmo_alarm_reg <= 1'b0;
            ov_alarm_reg     <= 1'b0;
        end else begin
            fb_tmo_alarm_reg <= fb_tmo_set | (fb_tmo_alarm_reg & ~clear_allowed);
            ov_alarm_reg     <= ov_now | (ov_alarm_reg & ~clear_allowed);
        end
    end

    // register file
    logic [EVT_W-1:0] status_reg, mask_reg;
    regen_cfg_t       regen_reg;
    logic             irq_reg;
    logic [31:0]      rdata_reg;
    logic             wait_reg;

    wire access    = (avs_read | avs_write) & wait_reg;
    wire wr_take   = avs_write & ~wait_reg;
    wire hit_stat  = (avs_address == ADDR_STATUS);
    wire hit_mask  = (avs_address == ADDR_MASK);
    wire hit_regen = (avs_address == ADDR_REGEN);
    wire hit_state = (avs_address == ADDR_STATE);
    wire [EVT_W-1:0] evt = {ready_next & ~ready_reg, active_next & ~active_reg,
                            ov_now & ~ov_alarm_reg, fb_tmo_set & ~fb_tmo_alarm_reg};
    wire [EVT_W-1:0] w1c = (wr_take && hit_stat && avs_byteenable[0]) ?
                           avs_writedata[EVT_W-1:0] : '0;
    wire [31:0] rd_mux = hit_stat  ? {28'h0, status_reg} :
                         hit_mask  ? {28'h0, mask_reg} :
                         hit_regen ? {16'h0, regen_reg} :
                         hit_state ? {16'h0, 2'h0, fb_tmo_alarm_reg, ov_alarm_reg,
                                      1'b0, state_reg, 3'h0, fb_reg, clr_reg, run_reg,
                                      active_reg, relay_reg} : 32'h0;

    // one wait cycle per access, then answer
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wait_reg  <= 1'b1;
            rdata_reg <= '0;
        end else begin
            wait_reg  <= ~access;
            rdata_reg <= (avs_read & wait_reg) ? rd_mux : rdata_reg;
        end
    end

    // status sticky, set wins over write-one clear
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            status_reg <= '0;
            mask_reg   <= MASK_RESET;
            regen_reg  <= REGEN_RESET;
            irq_reg    <= 1'b0;
        end else begin
            status_reg <= evt | (status_reg & ~w1c);
            if (wr_take && hit_mask && avs_byteenable[0]) begin
                mask_reg <= avs_writedata[EVT_W-1:0];
            end
            if (wr_take && hit_regen && avs_byteenable[0]) begin
                regen_reg.power <= avs_writedata[7:0];
            end
            if (wr_take && hit_regen && avs_byteenable[1]) begin
                regen_reg.resistance <= avs_writedata[15:8];
            end
            irq_reg <= |((evt | (status_reg & ~w1c)) & mask_reg);
        end
    end

    // regen resistor pwm, duty set by the power setting
    logic regen_sw;
    regen_pwm u_regen (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .vbus  (VBUS),
        .duty  (regen_reg.power),
        .sw_on (regen_sw)
    );

    assign SERVO_READY     = ready_reg;
    assign BRAKE_RELAY     = relay_reg;
    assign SERVO_ACTIVE    = active_reg;
    assign REGEN_SW        = regen_sw;
    assign IRQ             = irq_reg;
    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;
endmodule : dbrake_seq

// ==== verification/dbrake_seq_properties.sv ====
// port level checks for the dynamic brake sequencer
`timescale 1ns/10ps
module dbrake_seq_properties
    import dbrake_pkg::*;
(
    input wire logic              REF_CLK,         // control clock
    input wire logic              RSTN,            // async reset
    input wire logic              RUN_REQ,         // run request
    input wire logic              FAULT_CLEAR,     // alarm clear
    input wire logic              BRAKE_FB,        // relay feedback
    input wire logic [VBUS_W-1:0] VBUS,            // bus voltage
    input wire logic              SERVO_READY,     // ready output
    input wire logic              BRAKE_RELAY,     // relay output
    input wire logic              SERVO_ACTIVE,    // power stage
    input wire logic              REGEN_SW,        // regen switch
    input wire logic              avs_read,        // read strobe
    input wire logic              avs_write,       // write strobe
    input wire logic              avs_waitrequest  // stall
);
    localparam int ACT_WAIT = 1000;
    localparam int SLACK    = 16;
    logic [CNT_W-1:0] fb_wait_reg;  // relay on without active
    logic [CNT_W-1:0] rdy_wait_reg; // since reset or clear, no ready
    logic             clr_q_reg;    // clear pin last cycle
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    // helper counters for the long waits
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            fb_wait_reg  <= '0;
            rdy_wait_reg <= 24'h000001;
            clr_q_reg    <= 1'b0;
        end else begin
            clr_q_reg    <= FAULT_CLEAR;
            fb_wait_reg  <= (BRAKE_RELAY && !SERVO_ACTIVE) ? fb_wait_reg + 24'h000001 : '0;
            if (SERVO_READY)
                rdy_wait_reg <= '0;
            else if (FAULT_CLEAR && !clr_q_reg && !RUN_REQ)
                rdy_wait_reg <= 24'h000001;
            else if (rdy_wait_reg != '0)
                rdy_wait_reg <= rdy_wait_reg + 24'h000001;
        end
    end
    sequence relay_up_s;
        ##[1:ACT_WAIT] BRAKE_RELAY;
    endsequence
    sequence servo_up_s;
        ##[1:ACT_WAIT] SERVO_ACTIVE;
    endsequence
    relay_on_time_a: assert property ($rose(RUN_REQ) && SERVO_READY |-> relay_up_s)
        else $error("relay late after run");
    servo_on_time_a: assert property ($rose(BRAKE_FB) && RUN_REQ |-> servo_up_s)
        else $error("servo late after feedback");
    run_off_drop_a: assert property ($fell(RUN_REQ) |-> ##[1:ACT_WAIT] (!BRAKE_RELAY && !SERVO_ACTIVE))
        else $error("outputs stay on after run off");
    active_needs_fb_a: assert property ($rose(SERVO_ACTIVE) |-> BRAKE_RELAY && BRAKE_FB)
        else $error("servo on without relay");
    fb_timeout_a: assert property (fb_wait_reg <= FB_TIMEOUT_CYC + SLACK)
        else $error("feedback timeout missed");
    timeout_early_a: assert property ($fell(BRAKE_RELAY) && RUN_REQ |->
        fb_wait_reg >= FB_TIMEOUT_CYC - SLACK)
        else $error("timeout too early");
    alarm_drop_a: assert property ($fell(BRAKE_RELAY) && RUN_REQ |-> ##[0:8] !SERVO_READY)
        else $error("ready kept on alarm");
    overvolt_trip_a: assert property (VBUS >= OVERVOLT_V |-> ##[1:8] (!SERVO_READY && !BRAKE_RELAY))
        else $error("overvoltage not tripped");
    ready_run_off_a: assert property ($rose(SERVO_READY) |-> !RUN_REQ && !BRAKE_RELAY)
        else $error("ready back with run on");
    ready_time_a: assert property (rdy_wait_reg <= READY_CYC + SLACK)
        else $error("ready late after clear");
    regen_gate_a: assert property (REGEN_SW |->
        $past(VBUS) >= REGEN_ON_V || $past(VBUS, 2) >= REGEN_ON_V)
        else $error("regen on below threshold");
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
endmodule : dbrake_seq_properties
bind dbrake_seq dbrake_seq_properties u_dbrake_seq_properties (.REF_CLK, .RSTN, .RUN_REQ, .FAULT_CLEAR,
    .BRAKE_FB, .VBUS, .SERVO_READY, .BRAKE_RELAY, .SERVO_ACTIVE, .REGEN_SW, .avs_read, .avs_write, .avs_waitrequest);

// ==== verification/relay_model.sv ====
// braking relay model answering the relay output with feedback
`timescale 1ns/10ps
module relay_model (
    input  wire logic clk,   // control clock
    input  wire logic rst_n, // async reset
    input  wire logic coil,  // relay drive
    input  wire logic stuck, // contacts never report
    output logic      fb     // feedback contact
);
    logic [31:0] dly_reg; // contact travel time
    // feedback follows the coil after travel, drops after release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dly_reg <= '0;
        end else begin
            dly_reg <= {dly_reg[30:0], coil & ~stuck};
        end
    end
    assign fb = dly_reg[31];
endmodule : relay_model

// ==== verification/dbrake_seq_bench.sv ====
// self-checking bench for the dynamic brake sequencer
`timescale 1ns/10ps
module dbrake_seq_bench
    import dbrake_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        run_req = 1'b0;
    logic        fault_clear = 1'b0;
    logic        fb_stuck = 1'b0;
    logic [9:0]  vbus = 10'h12C;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] rd;
    wire         brake_fb, servo_ready, brake_relay, servo_active, regen_sw, irq, avs_waitrequest;
    wire  [31:0] avs_readdata;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          hits;
    always #25 ref_clk = ~ref_clk;
    dbrake_seq u_dbrake_seq (.REF_CLK(ref_clk), .RSTN(rstn), .RUN_REQ(run_req), .FAULT_CLEAR(fault_clear),
        .BRAKE_FB(brake_fb), .VBUS(vbus), .SERVO_READY(servo_ready), .BRAKE_RELAY(brake_relay),
        .SERVO_ACTIVE(servo_active), .REGEN_SW(regen_sw), .IRQ(irq), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    relay_model u_relay_model (.clk(ref_clk), .rst_n(rstn), .coil(brake_relay), .stuck(fb_stuck), .fb(brake_fb));
    task complete_run;
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    // one avalon access, held until waitrequest is sampled low
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task rchk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rchk
    task count_regen(input logic [31:0] exp);
        hits = 0;
        repeat (512) begin
            @(posedge ref_clk);
            if (regen_sw === 1'b1) hits++;
        end
        check(32'(hits), exp);
    endtask : count_regen
    task pulse_clear;
        fault_clear <= 1'b1;
        tick(10);
        fault_clear <= 1'b0;
        tick(10);
    endtask : pulse_clear
    // watchdog on the whole run
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000000) begin
            miscompares++;
            complete_run;
        end
    end
    initial begin
        tick(2);
        rstn <= 1'b1;
        rchk(ADDR_MASK, {28'h0, MASK_RESET});
        rchk(ADDR_REGEN, {16'h0, REGEN_RESET});
        rchk(4'h1, 32'h0);
        tick(READY_CYC + 50);
        check(servo_ready, 1'b1);
        rchk(ADDR_STATUS, 32'h8);
        check(irq, 1'b0);
        bus(1'b1, ADDR_MASK, 32'hF);
        tick(2);
        check(irq, 1'b1);
        bus(1'b1, ADDR_STATUS, 32'h8);
        tick(2);
        check(irq, 1'b0);
        // regen duty of one half, then just below threshold
        bus(1'b1, ADDR_REGEN, 32'h1E80);
        rchk(ADDR_REGEN, 32'h1E80);
        vbus <= REGEN_ON_V;
        tick(8);
        count_regen(32'd256);
        vbus <= REGEN_ON_V - 10'h001;
        tick(8);
        count_regen(32'd0);
        vbus <= 10'h12C;
        // normal run and stop
        run_req <= 1'b1;
        tick(1000);
        check({brake_relay, servo_active}, 2'b11);
        rchk(ADDR_STATUS, 32'h4);
        bus(1'b1, ADDR_STATUS, 32'hF);
        run_req <= 1'b0;
        tick(1000);
        check({servo_ready, brake_relay, servo_active}, 3'b100);
        // relay never reports, refused clear, overvoltage
        fb_stuck <= 1'b1;
        run_req <= 1'b1;
        tick(FB_TIMEOUT_CYC - 1000);
        check({brake_relay, servo_active}, 2'b10);
        tick(2000);
        check({servo_ready, brake_relay, servo_active}, 3'b000);
        check(irq, 1'b1);
        pulse_clear;
        tick(READY_CYC + 50);
        check(servo_ready, 1'b0);
        vbus <= OVERVOLT_V;
        tick(20);
        vbus <= 10'h12C;
        rchk(ADDR_STATUS, 32'h3);
        bus(1'b1, ADDR_STATUS, 32'h3);
        tick(2);
        check(irq, 1'b0);
        run_req <= 1'b0;
        tick(10);
        pulse_clear;
        tick(READY_CYC + 50);
        check(servo_ready, 1'b1);
        rchk(ADDR_STATUS, 32'h8);
        complete_run;
    end
endmodule : dbrake_seq_bench
